// ---- hdl/pwr_seq_pkg.sv ----
package pwr_seq_pkg;

    // ----------
    // Timing
    // ----------
    localparam int CLK_PERIOD_NS = 4;
    localparam int PLL_LOCK_MS = 2;
    // A least time, so the cycle count rounds up.
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_DELAY_CYCLES = 16384;
    localparam int EXEC_DELAY_CYCLES = 16;
    localparam int CRYSTAL_START_CYCLES = 1024;
    localparam int OLD_PAUSE_CYCLES = 2;
    localparam int NEW_PAUSE_CYCLES = 4;
    localparam int TMR_W = 20;
    localparam int EXEC_W = 16;
    localparam int PAUSE_W = 3;

    // ----------
    // Register map and fields
    // ----------
    localparam logic [11:0] OFS_CLOCK_CONTROL = 12'h000;
    localparam logic [11:0] OFS_CONFIG = 12'h004;
    localparam logic [11:0] OFS_TIMER1_CTRL = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam int IDLE_ON_HALT_BIT = 7;
    localparam int READY_FLAG_BIT = 3;
    localparam int CHOICE_LO = 0;
    localparam int T1_OSC_EN_BIT = 3;
    localparam int CFG_DELAY_EN_N_BIT = 0;
    localparam int CFG_MODE_LO = 4;
    localparam int ST_MODE_LO = 0;
    localparam int ST_CPU_CLK_BIT = 4;
    localparam int ST_PERIPH_CLK_BIT = 5;
    localparam int ST_CORE_RUN_BIT = 6;
    localparam int ST_PAUSE_BIT = 7;
    localparam int ST_SEQ_LO = 8;
    localparam logic [7:0] CFG_RESET_VAL = 8'h20;
    localparam logic [1:0] CHOICE_SECONDARY = 2'h1;

    // ----------
    // Primary clock configuration codes
    // ----------
    localparam logic [3:0] LOW_POWER_CRYSTAL_MODE = 4'h0;
    localparam logic [3:0] CRYSTAL_MODE = 4'h1;
    localparam logic [3:0] HIGH_SPEED_CRYSTAL_MODE = 4'h2;
    localparam logic [3:0] HIGH_SPEED_PLL_MODE = 4'h3;
    localparam logic [3:0] EXTERNAL_CLOCK_IN_MODE = 4'h4;
    localparam logic [3:0] EXTERNAL_CLOCK_IO_MODE = 4'h5;
    localparam logic [3:0] RESISTOR_CAPACITOR_OSC_MODE = 4'h6;
    localparam logic [3:0] RESISTOR_CAPACITOR_IO_MODE = 4'h7;
    localparam logic [3:0] INTERNAL_OSC_CLKOUT_MODE = 4'h8;
    localparam logic [3:0] INTERNAL_OSC_DUAL_IO_MODE = 4'h9;

    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} clk_src_type;
    typedef enum logic [2:0] {SEQ_WAIT_SUPPLY, SEQ_POWER_DELAY, SEQ_OSC_START, SEQ_PLL_LOCK, SEQ_READY} seq_type;
    typedef enum logic [1:0] {HALT_RUN, HALT_IDLE, HALT_SLEEP} halt_type;
    typedef enum logic [1:0] {SW_NONE, SW_OLD, SW_NEW} sw_type;
    typedef enum logic [2:0] {
        PRIMARY_RUN, SECONDARY_RUN, INTERNAL_OSC_RUN,
        PRIMARY_IDLE, SECONDARY_IDLE, INTERNAL_OSC_IDLE, SLEEP_MODE
    } power_mode_type;

    // Crystal modes need the start-up count; the PLL mode is a crystal mode too.
    function automatic logic isCrystal(input logic [3:0] mode);
        return mode == LOW_POWER_CRYSTAL_MODE || mode == CRYSTAL_MODE ||
               mode == HIGH_SPEED_CRYSTAL_MODE || mode == HIGH_SPEED_PLL_MODE;
    endfunction

    // The low choice bit is a don't-care once the high bit is set.
    function automatic clk_src_type srcOfChoice(input logic [1:0] choice);
        if (choice[1]) begin
            return SRC_INT;
        end
        return choice[0] ? SRC_SEC : SRC_PRI;
    endfunction

endpackage

// ---- hdl/delay_timer_if.sv ----
`timescale 1ns/1ps
interface delay_timer_if;
    logic start;
    logic tick;
    logic [pwr_seq_pkg::TMR_W-1:0] loadVal;
    logic done;
    logic busy;

    modport ctrl (output start, output tick, output loadVal, input done, input busy);
    modport tmr (input start, input tick, input loadVal, output done, output busy);
endinterface

// ---- hdl/startup_delay_timer.sv ----
`timescale 1ns/1ps
module startup_delay_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    delay_timer_if.tmr tmr
);

    typedef struct packed {
        logic [pwr_seq_pkg::TMR_W-1:0] count;
        logic done;
    } tmr_state_type;

    tmr_state_type tmrFf;
    tmr_state_type nxt_tmr;

    // ----------
    // Down counter
    // ----------
    // A start reloads even a running count, so the sequencer can chain
    // phases back to back without a gap cycle.
    always_comb begin
        nxt_tmr = tmrFf;
        nxt_tmr.done = 1'b0;
        if (tmr.start) begin
            nxt_tmr.count = tmr.loadVal;
        end else if (tmr.tick && tmrFf.count != '0) begin
            nxt_tmr.count = tmrFf.count - 1'b1;
            nxt_tmr.done = (tmrFf.count == pwr_seq_pkg::TMR_W'(1));
        end
    end

    // Register the whole state; low clock enable freezes it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmrFf <= '0;
        end else if (ce) begin
            tmrFf <= nxt_tmr;
        end
    end

    assign tmr.done = tmrFf.done;
    assign tmr.busy = tmrFf.count != '0;

endmodule // startup_delay_timer

// ---- hdl/power_up_delay_and_power_modes.sv ----
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Power-on delay runs only when its enable bit is zero.
// [RULE_02] Core reset held until supply and primary clock are stable.
// [RULE_03] Crystal modes count 1024 oscillator cycles before clocking the device.
// [RULE_04] PLL mode waits 2 ms more after the crystal count.
// [RULE_05] Primary-clock-ready flag sets once all start-up delays end.
// [RULE_06] Execution-start delay runs alongside the others, or alone.
// [RULE_07] In sleep, dual-IO frees both pins; RC-IO and external-IO free pin two.
// [RULE_08] In sleep, pin two is low in RC, clock-out and external modes.
// [RULE_09] Seven modes: three run, three idle, and sleep without a clock.
// [RULE_10] Halt-idle bit sets CPU clocking; choice bits pick the source.
// [RULE_11] Choice 00 primary, 01 secondary, 1x internal.
// [RULE_12] New choice switches at once if the source runs, after a pause.
// [RULE_13] Only SLEEP enters idle or sleep; bit zero gives sleep, clocks off.
// [RULE_14] Bit one gives idle: CPU stopped, peripherals on the chosen source.
// [RULE_15] Without SLEEP the CPU and peripherals are clocked.
// [RULE_16] Mode follows the halt-idle bit sampled when SLEEP executes.
// [RULE_17] Software sets choice or halt-idle bit before SLEEP.
// [RULE_18] Secondary selection ignored unless the timer1 oscillator is on.
// [RULE_19] A switch pauses two old plus three to four new cycles.
// [RULE_20] Power-on and execution-start delay lengths are parameters.
module power_up_delay_and_power_modes #(
    parameter int POWER_DELAY_CYCLES = pwr_seq_pkg::POWER_DELAY_CYCLES,
    parameter int EXEC_DELAY_CYCLES = pwr_seq_pkg::EXEC_DELAY_CYCLES,
    parameter int PLL_LOCK_CYCLES = pwr_seq_pkg::PLL_LOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supplyStable,
    input wire logic primTick,
    input wire logic secTick,
    input wire logic intTick,
    input wire logic secRunning,
    input wire logic intRunning,
    input wire logic sleepExec,
    input wire logic wakeReq,
    output logic coreReset_n,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic [1:0] clkSel,
    output logic clkPause,
    output logic portBit7Sel,
    output logic portBit6Sel,
    output logic osc2Out,
    output logic osc2Oe
);

    // ----------
    // State
    // ----------
    typedef struct packed {
        pwr_seq_pkg::seq_type seq;
        logic [pwr_seq_pkg::EXEC_W-1:0] execCnt;
        logic execDone;
        logic readyFlag;
        logic coreRun;
        logic idleOnHalt;
        logic [1:0] choice;
        logic t1En;
        logic [7:0] cfg;
        pwr_seq_pkg::clk_src_type activeSrc;
        pwr_seq_pkg::clk_src_type targetSrc;
        pwr_seq_pkg::sw_type sw;
        logic [pwr_seq_pkg::PAUSE_W-1:0] pauseCnt;
        pwr_seq_pkg::halt_type halt;
        logic [1:0] clkDiv;
        logic osc2Level;
        logic [31:0] rdata;
    } core_state_type;

    core_state_type coreFf;
    core_state_type nxt_core;
    delay_timer_if tmrBus();

    logic [3:0] oscMode;
    logic apbSetup;
    logic apbWrite;
    logic addrHit;
    logic srcRunning;
    logic oldTick;
    logic newTick;
    pwr_seq_pkg::clk_src_type reqSrc;
    pwr_seq_pkg::power_mode_type powerMode;

    startup_delay_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .tmr(tmrBus.tmr)
    );

    // Tick of a given source, used for both halves of the switch pause.
    function automatic logic srcTick(input pwr_seq_pkg::clk_src_type s, input logic p, input logic q,
                                     input logic r);
        case (s)
            pwr_seq_pkg::SRC_PRI: return p;
            pwr_seq_pkg::SRC_SEC: return q;
            default: return r;
        endcase
    endfunction

    // ----------
    // Decode
    // ----------
    assign oscMode = coreFf.cfg[pwr_seq_pkg::CFG_MODE_LO +: 4];
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && ce;
    assign addrHit = paddr == pwr_seq_pkg::OFS_CLOCK_CONTROL || paddr == pwr_seq_pkg::OFS_CONFIG ||
                     paddr == pwr_seq_pkg::OFS_TIMER1_CTRL || paddr == pwr_seq_pkg::OFS_STATUS;
    assign reqSrc = pwr_seq_pkg::srcOfChoice(coreFf.choice); // [RULE_11]
    assign oldTick = srcTick(coreFf.activeSrc, primTick, secTick, intTick);
    assign newTick = srcTick(coreFf.targetSrc, primTick, secTick, intTick);

    // A source may be switched to only while it is running.
    always_comb begin
        case (reqSrc)
            pwr_seq_pkg::SRC_PRI: srcRunning = coreFf.readyFlag;
            pwr_seq_pkg::SRC_SEC: srcRunning = secRunning && coreFf.t1En;
            default: srcRunning = intRunning;
        endcase
    end

    // Operating mode as software sees it; sleep overrides the source.
    always_comb begin
        case (coreFf.halt)
            pwr_seq_pkg::HALT_SLEEP: powerMode = pwr_seq_pkg::SLEEP_MODE; // [RULE_09]
            pwr_seq_pkg::HALT_IDLE: powerMode = pwr_seq_pkg::power_mode_type'(3'(coreFf.activeSrc) + 3'h3);
            default: powerMode = pwr_seq_pkg::power_mode_type'(3'(coreFf.activeSrc));
        endcase
    end

    // ----------
    // Next state
    // ----------
    // The timer is shared by the power-on, crystal and PLL phases; only one
    // of them is ever live, which saves two wide counters.
    always_comb begin
        nxt_core = coreFf;
        tmrBus.start = 1'b0;
        tmrBus.loadVal = '0;
        tmrBus.tick = 1'b1;

        // Start-up sequencer; a supply drop sends it back to the start.
        case (coreFf.seq)
            pwr_seq_pkg::SEQ_WAIT_SUPPLY: begin
                if (supplyStable) begin
                    nxt_core.execCnt = pwr_seq_pkg::EXEC_W'(EXEC_DELAY_CYCLES); // [RULE_06] [RULE_20]
                    if (!coreFf.cfg[pwr_seq_pkg::CFG_DELAY_EN_N_BIT]) begin
                        tmrBus.start = 1'b1; // [RULE_01]
                        tmrBus.loadVal = pwr_seq_pkg::TMR_W'(POWER_DELAY_CYCLES); // [RULE_20]
                        nxt_core.seq = pwr_seq_pkg::SEQ_POWER_DELAY;
                    end else begin
                        nxt_core.seq = pwr_seq_pkg::SEQ_OSC_START;
                    end
                end
            end
            pwr_seq_pkg::SEQ_POWER_DELAY: begin
                if (tmrBus.done) begin
                    nxt_core.seq = pwr_seq_pkg::SEQ_OSC_START;
                end
            end
            pwr_seq_pkg::SEQ_OSC_START: begin
                // Entry cycle: arm the crystal count, or skip it for non-crystal modes.
                if (!pwr_seq_pkg::isCrystal(oscMode)) begin
                    nxt_core.seq = pwr_seq_pkg::SEQ_READY;
                end else if (!tmrBus.busy && !tmrBus.done) begin
                    tmrBus.start = 1'b1;
                    tmrBus.loadVal = pwr_seq_pkg::TMR_W'(pwr_seq_pkg::CRYSTAL_START_CYCLES); // [RULE_03]
                end else begin
                    tmrBus.tick = primTick; // [RULE_03]
                    if (tmrBus.done && oscMode == pwr_seq_pkg::HIGH_SPEED_PLL_MODE) begin
                        tmrBus.start = 1'b1; // [RULE_04]
                        tmrBus.loadVal = pwr_seq_pkg::TMR_W'(PLL_LOCK_CYCLES);
                        nxt_core.seq = pwr_seq_pkg::SEQ_PLL_LOCK;
                    end else if (tmrBus.done) begin
                        nxt_core.seq = pwr_seq_pkg::SEQ_READY;
                    end
                end
            end
            pwr_seq_pkg::SEQ_PLL_LOCK: begin
                if (tmrBus.done) begin
                    nxt_core.seq = pwr_seq_pkg::SEQ_READY; // [RULE_04]
                end
            end
            pwr_seq_pkg::SEQ_READY: begin
                nxt_core.readyFlag = 1'b1; // [RULE_05]
            end
            default: nxt_core.seq = pwr_seq_pkg::SEQ_WAIT_SUPPLY;
        endcase

        // Execution-start delay counts beside the other phases.
        if (coreFf.seq != pwr_seq_pkg::SEQ_WAIT_SUPPLY) begin
            if (coreFf.execCnt != '0) begin
                nxt_core.execCnt = coreFf.execCnt - 1'b1; // [RULE_06]
            end
            nxt_core.execDone = coreFf.execCnt <= pwr_seq_pkg::EXEC_W'(1);
        end
        nxt_core.coreRun = coreFf.seq == pwr_seq_pkg::SEQ_READY && coreFf.execDone; // [RULE_02]

        if (!supplyStable) begin
            nxt_core.seq = pwr_seq_pkg::SEQ_WAIT_SUPPLY; // [RULE_02]
            nxt_core.readyFlag = 1'b0;
            nxt_core.execDone = 1'b0;
            nxt_core.coreRun = 1'b0;
            nxt_core.halt = pwr_seq_pkg::HALT_RUN;
            nxt_core.activeSrc = pwr_seq_pkg::SRC_PRI;
            nxt_core.sw = pwr_seq_pkg::SW_NONE;
        end

        // Glitch-free switch: two old-source cycles, then four new ones.
        case (coreFf.sw)
            pwr_seq_pkg::SW_NONE: begin
                if (coreFf.coreRun && coreFf.halt != pwr_seq_pkg::HALT_SLEEP && reqSrc != coreFf.activeSrc &&
                    srcRunning) begin
                    nxt_core.sw = pwr_seq_pkg::SW_OLD; // [RULE_12]
                    nxt_core.targetSrc = reqSrc;
                    nxt_core.pauseCnt = pwr_seq_pkg::PAUSE_W'(pwr_seq_pkg::OLD_PAUSE_CYCLES);
                end
            end
            pwr_seq_pkg::SW_OLD: begin
                if (oldTick) begin
                    nxt_core.pauseCnt = coreFf.pauseCnt - 1'b1;
                    if (coreFf.pauseCnt == pwr_seq_pkg::PAUSE_W'(1)) begin
                        nxt_core.sw = pwr_seq_pkg::SW_NEW; // [RULE_19]
                        nxt_core.pauseCnt = pwr_seq_pkg::PAUSE_W'(pwr_seq_pkg::NEW_PAUSE_CYCLES);
                    end
                end
            end
            pwr_seq_pkg::SW_NEW: begin
                if (newTick) begin
                    nxt_core.pauseCnt = coreFf.pauseCnt - 1'b1;
                    if (coreFf.pauseCnt == pwr_seq_pkg::PAUSE_W'(1)) begin
                        nxt_core.sw = pwr_seq_pkg::SW_NONE; // [RULE_19]
                        nxt_core.activeSrc = coreFf.targetSrc;
                    end
                end
            end
            default: nxt_core.sw = pwr_seq_pkg::SW_NONE;
        endcase

        // SLEEP samples the halt-idle bit in its own cycle; a wake request returns to run.
        if (coreFf.coreRun && coreFf.halt == pwr_seq_pkg::HALT_RUN && sleepExec) begin
            nxt_core.halt = coreFf.idleOnHalt ? pwr_seq_pkg::HALT_IDLE : pwr_seq_pkg::HALT_SLEEP; // [RULE_13] [RULE_16]
        end else if (coreFf.halt != pwr_seq_pkg::HALT_RUN && wakeReq) begin
            nxt_core.halt = pwr_seq_pkg::HALT_RUN; // [RULE_15]
        end

        // Instruction-rate clock on pin two: one toggle per two primary cycles.
        if (primTick) begin
            nxt_core.clkDiv = coreFf.clkDiv + 1'b1;
            nxt_core.osc2Level = coreFf.clkDiv[0] ? ~coreFf.osc2Level : coreFf.osc2Level;
        end

        // Register writes; writes take effect only in the access phase.
        if (apbWrite && paddr == pwr_seq_pkg::OFS_CLOCK_CONTROL) begin
            nxt_core.idleOnHalt = pwdata[pwr_seq_pkg::IDLE_ON_HALT_BIT]; // [RULE_10]
            if (pwdata[pwr_seq_pkg::CHOICE_LO +: 2] != pwr_seq_pkg::CHOICE_SECONDARY || coreFf.t1En) begin
                nxt_core.choice = pwdata[pwr_seq_pkg::CHOICE_LO +: 2]; // [RULE_10] [RULE_18]
            end
        end
        if (apbWrite && paddr == pwr_seq_pkg::OFS_CONFIG) begin
            nxt_core.cfg = pwdata[7:0];
        end
        if (apbWrite && paddr == pwr_seq_pkg::OFS_TIMER1_CTRL) begin
            nxt_core.t1En = pwdata[pwr_seq_pkg::T1_OSC_EN_BIT];
        end

        // Read data is captured in the setup phase, so it is a flop in the access phase.
        if (apbSetup) begin
            nxt_core.rdata = '0;
            case (paddr)
                pwr_seq_pkg::OFS_CLOCK_CONTROL: begin
                    nxt_core.rdata[pwr_seq_pkg::IDLE_ON_HALT_BIT] = coreFf.idleOnHalt;
                    nxt_core.rdata[pwr_seq_pkg::READY_FLAG_BIT] = coreFf.readyFlag; // [RULE_05]
                    nxt_core.rdata[pwr_seq_pkg::CHOICE_LO +: 2] = coreFf.choice;
                end
                pwr_seq_pkg::OFS_CONFIG: nxt_core.rdata[7:0] = coreFf.cfg;
                pwr_seq_pkg::OFS_TIMER1_CTRL: nxt_core.rdata[pwr_seq_pkg::T1_OSC_EN_BIT] = coreFf.t1En;
                pwr_seq_pkg::OFS_STATUS: begin
                    nxt_core.rdata[pwr_seq_pkg::ST_MODE_LO +: 3] = powerMode;
                    nxt_core.rdata[pwr_seq_pkg::ST_CPU_CLK_BIT] = cpuClkEn;
                    nxt_core.rdata[pwr_seq_pkg::ST_PERIPH_CLK_BIT] = periphClkEn;
                    nxt_core.rdata[pwr_seq_pkg::ST_CORE_RUN_BIT] = coreFf.coreRun;
                    nxt_core.rdata[pwr_seq_pkg::ST_PAUSE_BIT] = clkPause;
                    nxt_core.rdata[pwr_seq_pkg::ST_SEQ_LO +: 3] = coreFf.seq;
                end
                default: nxt_core.rdata = '0;
            endcase
        end
    end

    // Register the whole state; low clock enable freezes it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            coreFf <= '0;
            coreFf.cfg <= pwr_seq_pkg::CFG_RESET_VAL;
        end else if (ce) begin
            coreFf <= nxt_core;
        end
    end

    // ----------
    // Outputs
    // ----------
    // The bus never waits, except that a frozen block holds the transfer off.
    assign pready = ce;
    assign pslverr = psel && penable && !addrHit;
    assign prdata = coreFf.rdata;
    assign coreReset_n = coreFf.coreRun; // [RULE_02]
    assign clkPause = coreFf.sw != pwr_seq_pkg::SW_NONE; // [RULE_19]
    assign clkSel = coreFf.activeSrc; // [RULE_11]
    assign cpuClkEn = coreFf.coreRun && coreFf.halt == pwr_seq_pkg::HALT_RUN && !clkPause; // [RULE_14] [RULE_15]
    assign periphClkEn = coreFf.coreRun && coreFf.halt != pwr_seq_pkg::HALT_SLEEP && !clkPause; // [RULE_13]

    // Pin two carries the clock out only in the RC, clock-out and external-in modes; in sleep it is driven low.
    always_comb begin
        portBit7Sel = oscMode == pwr_seq_pkg::INTERNAL_OSC_DUAL_IO_MODE; // [RULE_07]
        portBit6Sel = oscMode == pwr_seq_pkg::INTERNAL_OSC_DUAL_IO_MODE ||
                      oscMode == pwr_seq_pkg::RESISTOR_CAPACITOR_IO_MODE ||
                      oscMode == pwr_seq_pkg::EXTERNAL_CLOCK_IO_MODE; // [RULE_07]
        osc2Oe = oscMode == pwr_seq_pkg::RESISTOR_CAPACITOR_OSC_MODE ||
                 oscMode == pwr_seq_pkg::INTERNAL_OSC_CLKOUT_MODE ||
                 oscMode == pwr_seq_pkg::EXTERNAL_CLOCK_IN_MODE;
        osc2Out = osc2Oe && coreFf.osc2Level && coreFf.halt != pwr_seq_pkg::HALT_SLEEP; // [RULE_08]
    end

endmodule // power_up_delay_and_power_modes

// ---- sim/pwr_seq_props.sv ----
`timescale 1ns/1ps
// Checks of the start-up sequence, the clock switch and the halt modes.
module pwr_seq_props #(parameter int EXEC_DELAY_CYCLES = 16) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supplyStable,
    input wire logic sleepExec,
    input wire logic coreReset_n,
    input wire logic cpuClkEn,
    input wire logic periphClkEn,
    input wire logic [1:0] clkSel,
    input wire logic clkPause,
    input wire logic portBit7Sel,
    input wire logic portBit6Sel,
    input wire logic osc2Out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] pauseCnt_ff;
    // Pause length in core cycles; six source ticks need at least six.
    always_ff @(posedge core_clk or negedge rst_n) begin
        pauseCnt_ff <= !rst_n ? 8'h00 : (clkPause ? pauseCnt_ff + 8'h01 : 8'h00);
    end
    property p_supply_loss; !supplyStable |=> !coreReset_n; endproperty
    a_supply_loss: assert property (p_supply_loss) else $error("core left running without supply");
    property p_release; $rose(coreReset_n) |-> supplyStable && $past(supplyStable, EXEC_DELAY_CYCLES); endproperty
    a_release: assert property (p_release) else $error("core released too early");
    property p_run_after; $rose(coreReset_n) |-> ##[0:1] (cpuClkEn && periphClkEn); endproperty
    a_run_after: assert property (p_run_after) else $error("no run mode after release");
    property p_sleep; sleepExec && cpuClkEn |=> !cpuClkEn; endproperty
    a_sleep: assert property (p_sleep) else $error("halt did not stop the core clock");
    property p_pause_len; $fell(clkPause) |-> pauseCnt_ff >= 8'h06; endproperty
    a_pause_len: assert property (p_pause_len) else $error("clock switch pause too short");
    // A supply loss drops back to the primary source with no pause.
    property p_sel_change; $changed(clkSel) |-> $past(clkPause) || !$past(supplyStable); endproperty
    a_sel_change: assert property (p_sel_change) else $error("source changed without a pause");
    property p_osc2_low; coreReset_n && !cpuClkEn && !periphClkEn && !clkPause |-> !osc2Out; endproperty
    a_osc2_low: assert property (p_osc2_low) else $error("clock-out pin not low in sleep");
    property p_ports; portBit7Sel |-> portBit6Sel; endproperty
    a_ports: assert property (p_ports) else $error("pin one freed without pin two");
endmodule // pwr_seq_props

// ---- sim/osc_source_model.sv ----
`timescale 1ns/1ps
// Oscillator sources: all run, each tick is a one-cycle pulse.
module osc_source_model (
    input wire logic core_clk,
    output logic primTick,
    output logic secTick,
    output logic intTick,
    output logic running
);
    logic [1:0] phase_ff = 2'h0;
    // Free phase count; the slow secondary makes a switch pause clearly longer than six cycles.
    always_ff @(posedge core_clk) begin
        phase_ff <= phase_ff + 2'h1;
    end
    // Primary every second cycle, secondary and internal every fourth.
    assign primTick = phase_ff[0];
    assign secTick = phase_ff == 2'h2;
    assign intTick = phase_ff == 2'h3;
    assign running = 1'b1;
endmodule // osc_source_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    localparam int PWR_D = 20;
    localparam int EXEC_D = 3;
    localparam int PLL_D = 30;
    localparam logic [11:0] CTRL = pwr_seq_pkg::OFS_CLOCK_CONTROL;
    localparam logic [11:0] STAT = pwr_seq_pkg::OFS_STATUS;
    logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic supplyStable = 1'b0, sleepExec = 1'b0, wakeReq = 1'b0, pready, pslverr, primTick, secTick, intTick;
    logic running, coreReset_n, cpuClkEn, periphClkEn, clkPause, portBit7Sel, portBit6Sel, osc2Out, osc2Oe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0] clkSel;
    int bad_count = 0, samples_checked = 0, n;
    power_up_delay_and_power_modes #(.POWER_DELAY_CYCLES(PWR_D), .EXEC_DELAY_CYCLES(EXEC_D),
        .PLL_LOCK_CYCLES(PLL_D)) DUT (.core_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .supplyStable, .primTick, .secTick, .intTick, .secRunning(running), .intRunning(running),
        .sleepExec, .wakeReq, .coreReset_n, .cpuClkEn, .periphClkEn, .clkSel, .clkPause, .portBit7Sel,
        .portBit6Sel, .osc2Out, .osc2Oe);
    osc_source_model osc (.core_clk, .primTick, .secTick, .intTick, .running);
    // Core clock at 250 MHz.
    initial forever #2 core_clk = ~core_clk;
    // Compares one value and counts the result.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, then an idle edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && w < 50) begin
            w++;
            @(posedge core_clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // New config, supply cycled, cycles to release counted.
    task automatic restart(input logic [7:0] cfg, output int cyc);
        apb(1'b1, pwr_seq_pkg::OFS_CONFIG, {24'h0, cfg});
        supplyStable <= 1'b0;
        repeat (3) @(posedge core_clk);
        supplyStable <= 1'b1;
        for (cyc = 0; coreReset_n !== 1'b1 && cyc < 5000; cyc++) @(posedge core_clk);
    endtask
    // A one-cycle halt or wake request, then time for the mode to settle.
    task automatic pulse(input logic slp);
        sleepExec <= slp;
        wakeReq <= !slp;
        @(posedge core_clk);
        sleepExec <= 1'b0;
        wakeReq <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // Waits, bounded, for the active source.
    task automatic waitSel(input logic [1:0] s);
        for (int w = 0; clkSel !== s && w < 100; w++) @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog; the sequence needs under 6000 cycles.
    initial begin
        #80000;
        bad_count++;
        stop_test();
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, pwr_seq_pkg::OFS_CONFIG, 32'h0);
        chk("config", 32'h20, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        restart(8'h20, n);
        chk("crystal start", 32'h1, 32'(n >= PWR_D + 2047 && n < PWR_D + 2100));
        apb(1'b0, CTRL, 32'h0);
        chk("ready flag", 32'h8, q);
        apb(1'b1, CTRL, 32'h1);
        apb(1'b0, CTRL, 32'h0);
        chk("secondary refused", 32'h8, q);
        apb(1'b1, pwr_seq_pkg::OFS_TIMER1_CTRL, 32'h8);
        apb(1'b1, CTRL, 32'h81);
        waitSel(2'h1);
        chk("source sec", 32'h1, 32'(clkSel));
        pulse(1'b1);
        chk("idle clocks", 32'h1, 32'({cpuClkEn, periphClkEn}));
        apb(1'b1, CTRL, 32'h1);
        apb(1'b0, STAT, 32'h0);
        chk("idle kept", 32'h4, q & 32'h7);
        pulse(1'b0);
        chk("run clocks", 32'h3, 32'({cpuClkEn, periphClkEn}));
        pulse(1'b1);
        apb(1'b0, STAT, 32'h0);
        chk("sleep", 32'h6, q & 32'h37);
        pulse(1'b0);
        apb(1'b1, CTRL, 32'h3);
        waitSel(2'h2);
        chk("source int", 32'h2, 32'(clkSel));
        for (int m = 0; m < 10; m++) begin
            apb(1'b1, pwr_seq_pkg::OFS_CONFIG, 32'(m * 16 + 1));
            chk("pin sel", 32'({m == 9, m == 5 || m == 7 || m == 9}), 32'({portBit7Sel, portBit6Sel}));
        end
        restart(8'h41, n);
        chk("ext start", 32'h1, 32'(n <= EXEC_D + 5));
        pulse(1'b1);
        chk("clkout sleep", 32'h2, 32'({osc2Oe, osc2Out}));
        pulse(1'b0);
        restart(8'h31, n);
        chk("pll start", 32'h1, 32'(n >= PLL_D + 2047 && n < PLL_D + 2100));
        stop_test();
    end
endmodule // tb_top
bind power_up_delay_and_power_modes pwr_seq_props #(.EXEC_DELAY_CYCLES(EXEC_DELAY_CYCLES)) props (.core_clk, .rst_n,
    .supplyStable, .sleepExec, .coreReset_n, .cpuClkEn, .periphClkEn, .clkSel, .clkPause, .portBit7Sel,
    .portBit6Sel, .osc2Out);
